// >>> pkg/ees_pkg.sv
// Shared constants and state encoding for the serial EEPROM slave.
package ees_pkg;
  // Array geometry: 8192 bytes, 32-byte pages.
  localparam int ADDR_W = 13;
  localparam int PAGE_W = 5;
  localparam int PAGE_N = 32;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Fixed upper nibble of every slave address.
  localparam logic [3:0] DEV_TYPE = 4'hA;
  // Clock rates expressed as periods or frequencies.
  localparam int SYS_MHZ = 200;
  localparam int LINK_PS = 6000;
  // Longest pulse the input filter must swallow.
  localparam int INPUT_GLITCH_FILTER_WIDTH_NS = 50;
  // A pulse of exactly the filter width can still span one sample more than
  // its whole periods, so the filter waits two samples beyond those periods.
  localparam int FILT_CYC =
    INPUT_GLITCH_FILTER_WIDTH_NS * 1000 / LINK_PS + 2;
  // Longest write cycle and power-up delay, rounded down.
  localparam int WRITE_CYCLE_TIME_US = 4000;
  localparam int WR_CYC = WRITE_CYCLE_TIME_US * SYS_MHZ;
  localparam int POWER_UP_READY_DELAY_US = 350;
  localparam int PU_CYC = POWER_UP_READY_DELAY_US * SYS_MHZ;
  // Protocol states, one-hot.
  typedef enum logic [7:0] {
    S_IDLE  = 8'h01,
    S_DEV   = 8'h02,
    S_AHI   = 8'h04,
    S_ALO   = 8'h08,
    S_WDATA = 8'h10,
    S_ACK   = 8'h20,
    S_RDATA = 8'h40,
    S_MACK  = 8'h80
  } ees_state_e;
endpackage : ees_pkg

// >>> core/ees_eeprom_slave.sv
// Two-wire serial EEPROM slave with page buffer and timed write cycle.
`timescale 1ns/100ps
`default_nettype none
module ees_eeprom_slave
  import ees_pkg::*;
#(
  parameter logic [2:0] VAR_BITS = 3'h0,
  parameter int         WR_CYCLES = WR_CYC,
  parameter int         PU_CYCLES = PU_CYC,
  parameter int         CNT_W     = 20
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic link_clk,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe
);
  // Counters must hold the longest count and be at least one cycle.
  if (WR_CYCLES < 1 || PU_CYCLES < 1 || WR_CYCLES >= 2**CNT_W
      || PU_CYCLES >= 2**CNT_W)
  begin : g_chk
    $error("Cycle counts do not fit the counter width.");
  end

  // The pin is open drain: the driven level is always low.
  assign sda_o = 1'b0;

  // System-domain state: power-up timer and write-cycle timer.
  logic [CNT_W-1:0] por_r, por_nxt;   // Power-up count.
  logic             rdy_r, rdy_nxt;   // Device ready after power-up.
  logic [CNT_W-1:0] wc_r, wc_nxt;     // Write cycle count.
  logic             run_r, run_nxt;   // Write cycle in progress.
  logic             dtg_r, dtg_nxt;   // Toggles when a cycle ends.
  logic [2:0]       cts_r;            // Commit toggle sync and history.
  logic             cmt_r;            // Link-side commit toggle.

  // Counts power-up delay and the self-timed write cycle.
  always_comb
  begin
    por_nxt = por_r;
    rdy_nxt = rdy_r;
    wc_nxt  = wc_r;
    run_nxt = run_r;
    dtg_nxt = dtg_r;
    if (!rdy_r)
    begin
      // Ready once the delay has run out.
      if (por_r == CNT_W'(PU_CYCLES - 1))
        rdy_nxt = 1'b1;
      else
        por_nxt = por_r + 1'b1;
    end
    if (cts_r[2] != cts_r[1])
    begin
      // A new commit starts the timer.
      run_nxt = 1'b1;
      wc_nxt  = '0;
    end
    else if (run_r)
    begin
      // Ending on the exact count keeps within the 4 ms bound.
      if (wc_r == CNT_W'(WR_CYCLES - 1))
      begin
        run_nxt = 1'b0;
        dtg_nxt = ~dtg_r;
      end
      else
        wc_nxt = wc_r + 1'b1;
    end
  end

  // Registers the system-domain state; reset models the supply monitor.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      por_r <= '0;
      rdy_r <= 1'b0;
      wc_r  <= '0;
      run_r <= 1'b0;
      dtg_r <= 1'b0;
      cts_r <= 3'h0;
    end
    else
    begin
      por_r <= por_nxt;
      rdy_r <= rdy_nxt;
      wc_r  <= wc_nxt;
      run_r <= run_nxt;
      dtg_r <= dtg_nxt;
      cts_r <= {cts_r[1:0], cmt_r};
    end
  end

  // Reset, ready level and done toggle brought into the link domain.
  logic       rst_m, rst_l;  // Reset synchroniser.
  logic [1:0] rdy_s;         // Ready synchroniser.
  logic [2:0] dts_r;         // Done toggle sync and history.

  // Plain synchronisers; each first stage feeds only its second stage.
  always_ff @(posedge link_clk)
  begin
    rst_m <= rst;
    rst_l <= rst_m;
    rdy_s <= {rdy_s[0], rdy_r};
    dts_r <= {dts_r[1:0], dtg_r};
  end

  // Input synchronisers and glitch filters for both bus lines.
  logic [1:0] pin_m, pin_s;  // Two-stage sync, index 0 clock, 1 data.
  logic [1:0] filt_r;        // Filtered line levels.
  logic [3:0] fc_r [2];      // Stability counters.

  // Two flops per pin; even the shortest fast-plus clock phase spans dozens of samples.
  always_ff @(posedge link_clk)
  begin
    pin_m <= {sda_i, scl_i};
    pin_s <= pin_m;
  end

  for (genvar g = 0; g < 2; g++)
  begin : g_filt
    logic       f_nxt;
    logic [3:0] c_nxt;
    // A new level must hold FILT_CYC samples before it is believed.
    always_comb
    begin
      f_nxt = filt_r[g];
      c_nxt = 4'h0;
      if (pin_s[g] != filt_r[g])
      begin
        if (fc_r[g] == 4'(FILT_CYC - 1))
          f_nxt = pin_s[g];
        else
          c_nxt = fc_r[g] + 4'h1;
      end
    end
    // Idle bus lines rest high.
    always_ff @(posedge link_clk)
    begin
      if (rst_l)
      begin
        filt_r[g] <= 1'b1;
        fc_r[g]   <= 4'h0;
      end
      else
      begin
        filt_r[g] <= f_nxt;
        fc_r[g]   <= c_nxt;
      end
    end
    AST_FILTER: assert property (@(posedge link_clk) disable iff (rst_l)
      $changed(filt_r[g]) |-> $past(fc_r[g]) == 4'(FILT_CYC - 1))
      else $error("Filtered line moved before the hold time.");
  end

  // Bus events taken from the filtered levels.
  logic scl_p, sda_p;
  logic rise, fall, start_ev, stop_ev, done_ev;
  assign rise     = filt_r[0] & ~scl_p;
  assign fall     = ~filt_r[0] & scl_p;
  assign start_ev = filt_r[0] & scl_p & sda_p & ~filt_r[1];
  assign stop_ev  = filt_r[0] & scl_p & ~sda_p & filt_r[1];
  assign done_ev  = dts_r[2] != dts_r[1];

  // Link-domain protocol state.
  ees_state_e        st_r, st_nxt;     // Protocol state.
  ees_state_e        ret_r, ret_nxt;   // State after the ack clock.
  logic [3:0]        cnt_r, cnt_nxt;   // Bit count in the byte.
  logic [7:0]        sh_r, sh_nxt;     // Receive shifter.
  logic [7:0]        tx_r, tx_nxt;     // Transmit shifter.
  logic              oe_r, oe_nxt;     // Pulling the data line low.
  logic [ADDR_W-1:0] ptr_r, ptr_nxt;   // Address pointer.
  logic [PAGE_N-1:0] mask_r, mask_nxt; // Loaded page entries.
  logic              busy_r, busy_nxt; // Write cycle running.
  logic              cmt_nxt;
  logic              more_r, more_nxt; // Master asked for another byte.
  logic              bwe, mwe;         // Buffer and array write strobes.
  logic [7:0]        pbuf [PAGE_N];    // Page write buffer.
  logic [7:0]        mem [2**ADDR_W];  // Storage array, not reset.
  logic [7:0]        rdata;

  assign rdata  = mem[ptr_r];
  assign sda_oe = oe_r;

  // Next-state logic of the slave; stop and start override the per-state logic.
  always_comb
  begin
    st_nxt   = st_r;
    ret_nxt  = ret_r;
    cnt_nxt  = cnt_r;
    sh_nxt   = sh_r;
    tx_nxt   = tx_r;
    oe_nxt   = oe_r;
    ptr_nxt  = ptr_r;
    mask_nxt = mask_r;
    busy_nxt = busy_r;
    cmt_nxt  = cmt_r;
    more_nxt = more_r;
    bwe      = 1'b0;
    mwe      = 1'b0;
    if (done_ev)
      busy_nxt = 1'b0;
    if (stop_ev)
    begin
      // A stop commits whatever the page holds in one cycle.
      if (|mask_r)
      begin
        mwe      = 1'b1;
        busy_nxt = 1'b1;
        cmt_nxt  = ~cmt_r;
        mask_nxt = '0;
      end
      st_nxt = S_IDLE;
      oe_nxt = 1'b0;
    end
    else if (start_ev)
    begin
      // A repeated start drops an uncommitted page.
      st_nxt   = S_DEV;
      cnt_nxt  = 4'h0;
      oe_nxt   = 1'b0;
      mask_nxt = '0;
    end
    else
    begin
      case (st_r)
        S_DEV, S_AHI, S_ALO, S_WDATA:
        begin
          if (rise)
          begin
            sh_nxt  = {sh_r[6:0], filt_r[1]};
            cnt_nxt = cnt_r + 4'h1;
          end
          else if (fall && cnt_r == BYTE_BITS)
          begin
            st_nxt  = S_ACK;
            cnt_nxt = 4'h0;
            oe_nxt  = 1'b1;
            if (st_r == S_DEV)
            begin
              // Wrong address, not ready or busy: stay silent.
              if (sh_r[7:1] != {DEV_TYPE, VAR_BITS} || !rdy_s[1] || busy_r)
              begin
                st_nxt = S_IDLE;
                oe_nxt = 1'b0;
              end
              else if (sh_r[0])
              begin
                ret_nxt = S_RDATA;
                tx_nxt  = rdata;
              end
              else
                ret_nxt = S_AHI;
            end
            else if (st_r == S_AHI)
            begin
              ptr_nxt[ADDR_W-1:8] = sh_r[ADDR_W-9:0];
              ret_nxt = S_ALO;
            end
            else if (st_r == S_ALO)
            begin
              ptr_nxt[7:0] = sh_r;
              ret_nxt = S_WDATA;
            end
            else
            begin
              // Only the in-page bits advance, so the page wraps.
              bwe = 1'b1;
              mask_nxt[ptr_r[PAGE_W-1:0]] = 1'b1;
              ptr_nxt[PAGE_W-1:0] = ptr_r[PAGE_W-1:0] + 1'b1;
              ret_nxt = S_WDATA;
            end
          end
        end
        S_ACK:
        begin
          if (fall)
          begin
            st_nxt = ret_r;
            oe_nxt = 1'b0;
            if (ret_r == S_RDATA)
            begin
              oe_nxt  = ~tx_r[7];
              cnt_nxt = 4'h1;
            end
          end
        end
        S_RDATA:
        begin
          if (fall)
          begin
            if (cnt_r == BYTE_BITS)
            begin
              // Release for the master's ack; pointer rolls over at the end.
              oe_nxt  = 1'b0;
              ptr_nxt = ptr_r + 1'b1;
              st_nxt  = S_MACK;
            end
            else
            begin
              oe_nxt  = ~tx_r[6];
              tx_nxt  = {tx_r[6:0], 1'b0};
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        S_MACK:
        begin
          if (rise)
            more_nxt = ~filt_r[1];
          else if (fall)
          begin
            st_nxt = S_IDLE;
            if (more_r)
            begin
              st_nxt  = S_RDATA;
              tx_nxt  = rdata;
              oe_nxt  = ~rdata[7];
              cnt_nxt = 4'h1;
            end
          end
        end
        default:
          st_nxt = st_r;
      endcase
    end
  end

  // Registers the link-domain control state.
  always_ff @(posedge link_clk)
  begin
    if (rst_l)
    begin
      st_r   <= S_IDLE;
      ret_r  <= S_IDLE;
      cnt_r  <= 4'h0;
      sh_r   <= 8'h00;
      tx_r   <= 8'h00;
      oe_r   <= 1'b0;
      ptr_r  <= '0;
      mask_r <= '0;
      busy_r <= 1'b0;
      cmt_r  <= 1'b0;
      more_r <= 1'b0;
      scl_p  <= 1'b1;
      sda_p  <= 1'b1;
    end
    else
    begin
      st_r   <= st_nxt;
      ret_r  <= ret_nxt;
      cnt_r  <= cnt_nxt;
      sh_r   <= sh_nxt;
      tx_r   <= tx_nxt;
      oe_r   <= oe_nxt;
      ptr_r  <= ptr_nxt;
      mask_r <= mask_nxt;
      busy_r <= busy_nxt;
      cmt_r  <= cmt_nxt;
      more_r <= more_nxt;
      scl_p  <= filt_r[0];
      sda_p  <= filt_r[1];
    end
  end

  // Buffer and array storage; contents are nonvolatile, so never reset.
  always_ff @(posedge link_clk)
  begin
    if (bwe)
      pbuf[ptr_r[PAGE_W-1:0]] <= sh_r;
    for (int i = 0; i < PAGE_N; i++)
    begin
      if (mwe && mask_r[i])
        mem[{ptr_r[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= pbuf[i];
    end
  end

  AST_OE_AFTER_FALL: assert property (@(posedge link_clk) disable iff (rst_l)
    $rose(oe_r) |-> $past(fall))
    else $error("Data line pulled low away from a falling clock.");
  AST_BUSY_NOACK: assert property (@(posedge link_clk) disable iff (rst_l)
    (st_r == S_DEV && busy_r) |=> !oe_r)
    else $error("Acknowledge given during a write cycle.");
  AST_ADDR_MISS: assert property (@(posedge link_clk) disable iff (rst_l)
    (st_r == S_DEV && fall && cnt_r == BYTE_BITS && !start_ev && !stop_ev
     && sh_r[7:1] != {DEV_TYPE, VAR_BITS}) |=> st_r == S_IDLE && !oe_r)
    else $error("Foreign address was acknowledged.");
  AST_PAGE_WRAP: assert property (@(posedge link_clk) disable iff (rst_l)
    (bwe) |=> ptr_r[ADDR_W-1:PAGE_W] == $past(ptr_r[ADDR_W-1:PAGE_W]))
    else $error("Page load left its page.");
  AST_SEQ_WRAP: assert property (@(posedge link_clk) disable iff (rst_l)
    (st_r == S_RDATA && fall && cnt_r == BYTE_BITS && !stop_ev && !start_ev)
    |=> ptr_r == $past(ptr_r) + 1'b1 && st_r == S_MACK)
    else $error("Read pointer did not advance.");
  AST_WR_END: assert property (@(posedge clock) disable iff (rst)
    (run_r && wc_r == CNT_W'(WR_CYCLES - 1) && cts_r[2] == cts_r[1])
    |=> !run_r && dtg_r != $past(dtg_r))
    else $error("Write cycle overran its time.");
  AST_PU_READY: assert property (@(posedge clock) disable iff (rst)
    (!rdy_r && por_r == CNT_W'(PU_CYCLES - 1)) |=> rdy_r)
    else $error("Device not ready after power-up delay.");
  AST_RESET_HOLD: assert property (@(posedge clock)
    rst |=> !rdy_r && por_r == '0)
    else $error("Reset did not clear readiness.");
endmodule : ees_eeprom_slave
`default_nettype wire

// >>> testbench/ees_bus_master.sv
// Bus master model that clocks transfers on the two-wire link.
`timescale 1ns/100ps
`default_nettype none
module ees_bus_master
#(
  parameter int QTR = 50  // Quarter of a 1 MHz bit time in clock cycles.
) (
  input  wire logic clock,
  input  wire logic sda,
  output var  logic scl,
  output var  logic pull
);
  // The bus idles with the clock high and data left to the pull-up.
  initial
  begin
    scl  = 1'b1;
    pull = 1'b0;
  end

  // Sets both lines just after an edge and holds them for n cycles.
  task automatic step(input logic c, input logic p, input int n);
    @(posedge clock);
    scl  <= c;
    pull <= p;
    repeat (n - 1) @(posedge clock);
  endtask : step

  // Data moves only while the clock is low, so it reads as a bit.
  task automatic bit_io(input logic b, output logic r);
    step(1'b0, pull, QTR);
    step(1'b0, ~b, QTR);
    step(1'b1, ~b, QTR);
    r = sda;
    step(1'b1, ~b, QTR);
  endtask : bit_io

  // Data falls while the clock is high.
  task automatic start_cond();
    step(1'b0, pull, QTR);
    step(1'b0, 1'b0, QTR);
    step(1'b1, 1'b0, 2 * QTR);
    step(1'b1, 1'b1, 2 * QTR);
  endtask : start_cond

  // Data rises while the clock is high, then the bus is free.
  task automatic stop_cond();
    step(1'b0, pull, QTR);
    step(1'b0, 1'b1, QTR);
    step(1'b1, 1'b1, 2 * QTR);
    step(1'b1, 1'b0, 2 * QTR);
  endtask : stop_cond

  // A 30 ns low pulse on the clock, short enough to be swallowed.
  task automatic glitch();
    step(1'b0, pull, 6);
    step(1'b1, pull, 2 * QTR);
  endtask : glitch

  // Sends a byte MSB first and returns the acknowledge seen in bit nine.
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wr_byte

  // Releases data for eight bits, then answers with ACK or NoACK.
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask : rd_byte
endmodule : ees_bus_master
`default_nettype wire

// >>> testbench/test_ees_eeprom_slave.sv
// Self-checking bench for the serial EEPROM slave.
`timescale 1ns/100ps
`default_nettype none
module test_ees_eeprom_slave
  import ees_pkg::*;
;
  localparam int WRC = 3000;    // Shortened write cycle.
  localparam int PUC = 3000;    // Shortened power-up delay, longer than one byte.
  localparam int TMO = 120000;  // Ceiling on the whole run; it needs about 106000.
  localparam logic [7:0] AW = {DEV_TYPE, 3'h0, 1'b0};  // Write address.
  localparam logic [7:0] AR = {DEV_TYPE, 3'h0, 1'b1};  // Read address.
  logic clock    = 1'b0;  // System clock.
  logic link_clk = 1'b0;  // Link sampling clock.
  logic rst      = 1'b1;  // Supply-low reset.
  logic scl_i;            // Bus clock from the master.
  logic sda_i;            // Wired data level.
  logic sda_o;            // Device output value.
  logic sda_oe;           // Device pulls data low.
  logic pull;             // Master pulls data low.
  logic prev_scl;         // Bus clock one cycle ago.
  logic prev_oe;          // Device pull one cycle ago.
  int   err_count       = 0;
  int   samples_checked = 0;
  int   cycles          = 0;

  always #2.5 clock = ~clock;
  // The link clock drifts against the system clock on purpose.
  always #3.0 link_clk = ~link_clk;
  // Either party pulling wins; otherwise the pull-up holds the line high.
  assign sda_i = (pull | sda_oe) ? 1'b0 : 1'b1;

  ees_eeprom_slave #(.VAR_BITS(3'h0), .WR_CYCLES(WRC), .PU_CYCLES(PUC), .CNT_W(20))
    i_ees_eeprom_slave (.clock(clock), .rst(rst), .link_clk(link_clk), .scl_i(scl_i),
                        .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));
  ees_bus_master i_ees_bus_master (.clock(clock), .sda(sda_i), .scl(scl_i), .pull(pull));

  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Sends one byte and compares the acknowledge with the expected one.
  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic a;
    i_ees_bus_master.wr_byte(d, a);
    chk({7'h00, a}, {7'h00, exp_ack});
  endtask : send

  // Reads one byte and compares it.
  task automatic recv(input logic ack, input logic [7:0] exp);
    logic [7:0] d;
    i_ees_bus_master.rd_byte(ack, d);
    chk(d, exp);
  endtask : recv

  // The device stays silent while reset has only just released; the next
  // address lands some 1300 cycles after the delay has run out.
  task automatic t_not_ready();
    i_ees_bus_master.start_cond();
    send(AW, 1'b0);
    i_ees_bus_master.stop_cond();
  endtask : t_not_ready

  // Another variant's address and a wrong type nibble are both refused;
  // a repeated start separates the two requests.
  task automatic t_refused();
    i_ees_bus_master.start_cond();
    send({DEV_TYPE, 3'h4, 1'b0}, 1'b0);
    i_ees_bus_master.start_cond();
    send({4'hB, 3'h0, 1'b0}, 1'b0);
    i_ees_bus_master.stop_cond();
  endtask : t_refused

  // Polls until acknowledged; a poll takes 2400 cycles, so the
  // shortened write cycle must refuse one or two of them, never more.
  task automatic t_poll();
    int   nack;
    logic a;
    nack = 0;
    a    = 1'b0;
    while (a !== 1'b1 && nack < 4)
    begin
      i_ees_bus_master.start_cond();
      i_ees_bus_master.wr_byte(AW, a);
      i_ees_bus_master.stop_cond();
      if (a !== 1'b1)
        nack++;
    end
    chk({7'h00, (nack >= 1 && nack <= 2 && a === 1'b1)}, 8'h01);
  endtask : t_poll

  // Writes the last location of the array.
  task automatic t_write_top();
    i_ees_bus_master.start_cond();
    send(AW, 1'b1);
    send(8'h1F, 1'b1);
    send(8'hFF, 1'b1);
    send(8'h5A, 1'b1);
    i_ees_bus_master.stop_cond();
    t_poll();
  endtask : t_write_top

  // Loads 33 bytes into page zero; the last one wraps onto offset zero.
  task automatic t_page();
    i_ees_bus_master.start_cond();
    send(AW, 1'b1);
    send(8'h00, 1'b1);
    send(8'h00, 1'b1);
    for (int k = 0; k <= 32; k++)
      send(8'h10 + k[7:0], 1'b1);
    i_ees_bus_master.stop_cond();
    t_poll();
  endtask : t_page

  // Selective read at the top, then one more byte across the wrap.
  task automatic t_seq_read();
    i_ees_bus_master.start_cond();
    send(AW, 1'b1);
    send(8'h1F, 1'b1);
    send(8'hFF, 1'b1);
    i_ees_bus_master.start_cond();
    send(AR, 1'b1);
    recv(1'b1, 8'h5A);
    recv(1'b0, 8'h30);
    i_ees_bus_master.stop_cond();
  endtask : t_seq_read

  // Read with no address phase after a clock glitch; pointer now at 1.
  task automatic t_immediate();
    i_ees_bus_master.start_cond();
    i_ees_bus_master.glitch();
    send(AR, 1'b1);
    recv(1'b0, 8'h11);
    i_ees_bus_master.stop_cond();
  endtask : t_immediate

  // The device may only pull low, and only changes while the clock is low.
  always @(posedge clock)
  begin
    if (!rst && scl_i && prev_scl && sda_oe !== prev_oe)
      chk({7'h00, sda_oe}, {7'h00, prev_oe});
    if (sda_oe === 1'b1)
      chk({7'h00, sda_o}, 8'h00);
    prev_scl <= scl_i;
    prev_oe  <= sda_oe;
  end

  // A hang counts as a mismatch and closes the run.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == TMO)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  // Main sequence.
  initial
  begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_not_ready();
    t_refused();
    t_write_top();
    t_page();
    t_seq_read();
    t_immediate();
    tally_and_finish();
  end
endmodule : test_ees_eeprom_slave
`default_nettype wire
